/* verilog/fbo_pkg.sv */
package fbo_pkg;
   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_CTRL   = 6'h02;
   localparam logic [5:0] IDX_WIDTH  = 6'h0f;
   localparam logic [5:0] IDX_STL    = 6'h10;
   localparam logic [5:0] IDX_STH    = 6'h11;
   localparam logic [5:0] IDX_VLEN   = 6'h12;
   localparam logic [5:0] IDX_HSTART = 6'h13;
   localparam logic [5:0] IDX_HWIDTH = 6'h14;
   localparam logic [5:0] IDX_STATUS = 6'h15;
   localparam logic [5:0] IDX_CONFIG = 6'h16;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int CTRL_W       = 10;
   localparam int BIT_GTR      = 1;
   localparam int BIT_DBUF     = 4;
   localparam int BIT_OUTEN    = 6;
   localparam int BIT_BYPASS   = 7;
   localparam int BIT_HANDSH   = 8;
   localparam int BIT_FLOCK    = 9;
   localparam int CFG_W        = 2;
   localparam int BIT_YUV      = 0;
   localparam int BIT_INTERLC  = 1;
   localparam int CNT_W        = 11;
   localparam int STL_W        = 12;
   localparam int STH_W        = 7;
   localparam int ADDR_W       = STL_W + STH_W;
   localparam int PIX_W        = 24;
   localparam int STAT_LINE_LO = 16;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
   localparam logic [CFG_W-1:0]  CFG_RST  = 2'h0;
   localparam logic [CNT_W-1:0]  CNT_RST  = 11'h000;
   localparam logic [31:0]       RD_NONE  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Output sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FBO_IDLE   = 3'b001,
      FBO_DELAY  = 3'b010,
      FBO_ACTIVE = 3'b100
   } fbo_state_e;
endpackage : fbo_pkg

/* verilog/fbo_sync.sv */
`timescale 1ns/1ps
module fbo_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // Asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : fbo_sync

/* verilog/fbo_line_buf.sv */
`timescale 1ns/1ps
module fbo_line_buf #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             flush,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rd_r];
   assign push      = in_valid & in_ready & ~flush;
   assign pop       = out_valid & out_ready & ~flush;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else if (flush) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : fbo_line_buf

/* verilog/fbo_port.sv */
`timescale 1ns/1ps
module fbo_port #(
   parameter int BUF_DEPTH = 16
) (
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst,
   // Avalon-MM slave
   input  wire logic [7:0]               avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic      [31:0]              avs_readdata,
   output logic                          avs_waitrequest,
   // Scaler link
   input  wire logic                     port_reference_clock,
   input  wire logic                     line_request_in_n,
   input  wire logic                     frame_restart_in_n,
   input  wire logic                     data_request_in,
   output logic                          forwarded_pixel_clock,
   output logic      [fbo_pkg::PIX_W-1:0] pixel_bus_out,
   output logic                          line_sync_out,
   output logic                          frame_sync_out,
   output logic                          odd_field_flag,
   output logic                          supply_stall,
   output logic                          resync_pulse_out_n,
   // Frame store side
   input  wire logic [fbo_pkg::PIX_W-1:0] store_pixel_data,
   input  wire logic                     store_pixel_valid,
   output logic                          store_pixel_ready,
   output logic                          store_fetch_start,
   output logic      [fbo_pkg::ADDR_W-1:0] store_fetch_addr,
   output logic      [fbo_pkg::CNT_W-1:0] store_fetch_len,
   output logic                          store_double_buffer,
   output logic                          store_passthrough,
   output logic                          store_output_exceeds
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [fbo_pkg::CTRL_W-1:0] ctrl_r;
   logic [fbo_pkg::CFG_W-1:0]  cfg_r;
   logic [fbo_pkg::CNT_W-1:0]  width_r;
   logic [fbo_pkg::STL_W-1:0]  stl_r;
   logic [fbo_pkg::STH_W-1:0]  sth_r;
   logic [fbo_pkg::CNT_W-1:0]  vlen_r;
   logic [fbo_pkg::CNT_W-1:0]  hstart_r;
   logic [fbo_pkg::CNT_W-1:0]  hwidth_r;
   logic                       ack_r;
   logic [31:0]                rd_nxt;
   logic [5:0]                 idx;
   logic                       wr_go;

   fbo_pkg::fbo_state_e        st_r;
   logic [fbo_pkg::CNT_W-1:0]  dly_r;
   logic [fbo_pkg::CNT_W-1:0]  pix_cnt_r;
   logic [fbo_pkg::CNT_W-1:0]  line_cnt_r;
   logic [fbo_pkg::ADDR_W-1:0] line_addr_r;
   logic                       restart_pend_r;
   logic                       line_pend_r;
   logic                       ref_d_r;
   logic                       line_request_in_d_r;
   logic                       frst_d_r;
   logic [2:0]                 sync_v;
   logic                       ref_s;
   logic                       line_request_in_s;
   logic                       frst_s;
   logic                       tick;
   logic                       restart_evt;
   logic                       line_evt;
   logic                       outen;
   logic                       take_line;
   logic                       do_pix;
   logic [fbo_pkg::PIX_W-1:0]  buf_data;
   logic                       buf_valid;
   logic                       buf_pop;
   logic                       flush;
   logic [fbo_pkg::PIX_W-1:0]  mapped;

   assign idx   = avs_address[7:2];
   assign wr_go = avs_write & ack_r;
   assign outen = ctrl_r[fbo_pkg::BIT_OUTEN];

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [15:0] m;
      m     = {{8{be[1]}}, {8{be[0]}}};
      merge = (old & ~m) | (wd[15:0] & m);
   endfunction : merge

   // ----------------------------------------------------------------
   // Avalon slave: one wait state, answer on the second edge
   // ----------------------------------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   always_comb begin
      rd_nxt = fbo_pkg::RD_NONE;
      case (idx)
         fbo_pkg::IDX_CTRL:   rd_nxt = 32'(ctrl_r);
         fbo_pkg::IDX_WIDTH:  rd_nxt = 32'(width_r);
         fbo_pkg::IDX_STL:    rd_nxt = 32'(stl_r);
         fbo_pkg::IDX_STH:    rd_nxt = 32'(sth_r);
         fbo_pkg::IDX_VLEN:   rd_nxt = 32'(vlen_r);
         fbo_pkg::IDX_HSTART: rd_nxt = 32'(hstart_r);
         fbo_pkg::IDX_HWIDTH: rd_nxt = 32'(hwidth_r);
         fbo_pkg::IDX_CONFIG: rd_nxt = 32'(cfg_r);
         fbo_pkg::IDX_STATUS: rd_nxt = {5'h00, line_cnt_r, 11'h000, st_r, odd_field_flag, supply_stall};
         default:             rd_nxt = fbo_pkg::RD_NONE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         avs_readdata <= fbo_pkg::RD_NONE;
      end else if (avs_read & ~ack_r) begin
         avs_readdata <= rd_nxt;
      end
   end

   // Unmapped writes are dropped silently
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_r   <= fbo_pkg::CTRL_RST;
         cfg_r    <= fbo_pkg::CFG_RST;
         width_r  <= fbo_pkg::CNT_RST;
         stl_r    <= '0;
         sth_r    <= '0;
         vlen_r   <= fbo_pkg::CNT_RST;
         hstart_r <= fbo_pkg::CNT_RST;
         hwidth_r <= fbo_pkg::CNT_RST;
      end else if (wr_go) begin
         case (idx)
            fbo_pkg::IDX_CTRL:   ctrl_r   <= fbo_pkg::CTRL_W'(merge(16'(ctrl_r), avs_writedata, avs_byteenable));
            fbo_pkg::IDX_CONFIG: cfg_r    <= fbo_pkg::CFG_W'(merge(16'(cfg_r), avs_writedata, avs_byteenable));
            fbo_pkg::IDX_WIDTH:  width_r  <= fbo_pkg::CNT_W'(merge(16'(width_r), avs_writedata, avs_byteenable));
            fbo_pkg::IDX_STL:    stl_r    <= fbo_pkg::STL_W'(merge(16'(stl_r), avs_writedata, avs_byteenable));
            fbo_pkg::IDX_STH:    sth_r    <= fbo_pkg::STH_W'(merge(16'(sth_r), avs_writedata, avs_byteenable));
            fbo_pkg::IDX_VLEN:   vlen_r   <= fbo_pkg::CNT_W'(merge(16'(vlen_r), avs_writedata, avs_byteenable));
            fbo_pkg::IDX_HSTART: hstart_r <= fbo_pkg::CNT_W'(merge(16'(hstart_r), avs_writedata, avs_byteenable));
            fbo_pkg::IDX_HWIDTH: hwidth_r <= fbo_pkg::CNT_W'(merge(16'(hwidth_r), avs_writedata, avs_byteenable));
            default: ;
         endcase
      end
   end

   assign store_double_buffer  = ctrl_r[fbo_pkg::BIT_DBUF];
   assign store_passthrough    = ctrl_r[fbo_pkg::BIT_BYPASS];
   assign store_output_exceeds = ctrl_r[fbo_pkg::BIT_GTR];

   // ----------------------------------------------------------------
   // Link inputs and edge detection
   // ----------------------------------------------------------------
   // Data request is tied low in this connection and not used
   fbo_sync #(.WIDTH(3)) u_sync (
      .mclk     (mclk),
      .rst      (rst),
      .async_in ({port_reference_clock, line_request_in_n, frame_restart_in_n}),
      .sync_out (sync_v)
   );

   assign ref_s  = sync_v[2];
   assign line_request_in_s = sync_v[1];
   assign frst_s = sync_v[0];

   // Same reset as the synchroniser, so the idle pins raise no false edge after reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ref_d_r  <= 1'b0;
         line_request_in_d_r <= 1'b0;
         frst_d_r <= 1'b0;
      end else begin
         ref_d_r  <= ref_s;
         line_request_in_d_r <= line_request_in_s;
         frst_d_r <= frst_s;
      end
   end

   // Outputs move on the reference's falling edge so they are steady at the scaler's rising edge
   assign tick                  = ref_d_r & ~ref_s;
   assign forwarded_pixel_clock = ref_d_r;
   assign restart_evt           = frst_d_r & ~frst_s;
   assign line_evt              = line_request_in_d_r & ~line_request_in_s;

   // Events wait for the next tick; a new event beats the clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         restart_pend_r <= 1'b0;
      end else if (restart_evt) begin
         restart_pend_r <= 1'b1;
      end else if (tick) begin
         restart_pend_r <= 1'b0;
      end
   end

   assign take_line = tick & line_pend_r & ~restart_pend_r & (st_r == fbo_pkg::FBO_IDLE) & outen;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         line_pend_r <= 1'b0;
      end else if (line_evt) begin
         line_pend_r <= 1'b1;
      end else if (take_line | (tick & restart_pend_r)) begin
         line_pend_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Line buffer and pixel mapping
   // ----------------------------------------------------------------
   assign flush   = tick & restart_pend_r;
   assign do_pix  = tick & ~restart_pend_r & ((st_r == fbo_pkg::FBO_ACTIVE) |
                    ((st_r == fbo_pkg::FBO_DELAY) & (dly_r == 11'h001)));
   assign buf_pop = do_pix & buf_valid;

   fbo_line_buf #(.WIDTH(fbo_pkg::PIX_W), .DEPTH(BUF_DEPTH)) u_buf (
      .mclk      (mclk),
      .rst       (rst),
      .flush     (flush),
      .in_data   (store_pixel_data),
      .in_valid  (store_pixel_valid),
      .in_ready  (store_pixel_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (buf_pop)
   );

   // Luma/chroma fills the outer bytes; the middle byte reads zero
   assign mapped = cfg_r[fbo_pkg::BIT_YUV] ? {buf_data[15:8], 8'h00, buf_data[7:0]} : buf_data;

   // ----------------------------------------------------------------
   // Output sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r       <= fbo_pkg::FBO_IDLE;
         dly_r      <= fbo_pkg::CNT_RST;
         pix_cnt_r  <= fbo_pkg::CNT_RST;
         line_cnt_r <= fbo_pkg::CNT_RST;
      end else if (tick & restart_pend_r) begin
         st_r       <= fbo_pkg::FBO_IDLE;
         line_cnt_r <= fbo_pkg::CNT_RST;
         pix_cnt_r  <= fbo_pkg::CNT_RST;
      end else if (take_line) begin
         pix_cnt_r <= fbo_pkg::CNT_RST;
         if ((line_cnt_r < vlen_r) && (hwidth_r != fbo_pkg::CNT_RST)) begin
            line_cnt_r <= line_cnt_r + 1'b1;
            if (ctrl_r[fbo_pkg::BIT_HANDSH] && (hstart_r != fbo_pkg::CNT_RST)) begin
               st_r  <= fbo_pkg::FBO_DELAY;
               dly_r <= hstart_r;
            end else begin
               st_r <= fbo_pkg::FBO_ACTIVE;
            end
         end
      end else if (tick & (st_r == fbo_pkg::FBO_DELAY) & (dly_r != 11'h001)) begin
         dly_r <= dly_r - 1'b1;
      end else if (buf_pop) begin
         pix_cnt_r <= pix_cnt_r + 1'b1;
         if (pix_cnt_r + 1'b1 == hwidth_r) begin
            st_r <= fbo_pkg::FBO_IDLE;
         end else begin
            st_r <= fbo_pkg::FBO_ACTIVE;
         end
      end
   end

   // Stall holds the last pixel until the buffer catches up
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pixel_bus_out <= '0;
         supply_stall  <= 1'b0;
      end else if (do_pix) begin
         supply_stall <= ~buf_valid;
         if (buf_valid) begin
            pixel_bus_out <= mapped;
         end
      end else if (tick) begin
         supply_stall <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         frame_sync_out     <= 1'b0;
         line_sync_out      <= 1'b0;
         resync_pulse_out_n <= 1'b1;
         odd_field_flag     <= 1'b0;
      end else if (tick) begin
         frame_sync_out     <= restart_pend_r & outen;
         line_sync_out      <= take_line;
         resync_pulse_out_n <= ~(restart_pend_r & outen & ctrl_r[fbo_pkg::BIT_FLOCK]);
         if (~cfg_r[fbo_pkg::BIT_INTERLC]) begin
            odd_field_flag <= 1'b0;
         end else if (restart_pend_r) begin
            odd_field_flag <= ~odd_field_flag;
         end
      end
   end

   // ----------------------------------------------------------------
   // Frame store line fetch
   // ----------------------------------------------------------------
   // Start address counts pixels, so each fetched line moves the window on by the programmed width
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         line_addr_r       <= '0;
         store_fetch_start <= 1'b0;
         store_fetch_addr  <= '0;
         store_fetch_len   <= fbo_pkg::CNT_RST;
      end else begin
         store_fetch_start <= 1'b0;
         if (tick & restart_pend_r) begin
            line_addr_r <= {sth_r, stl_r};
         end else if (take_line && (line_cnt_r < vlen_r) && (hwidth_r != fbo_pkg::CNT_RST)) begin
            store_fetch_start <= 1'b1;
            store_fetch_addr  <= line_addr_r;
            store_fetch_len   <= width_r;
            line_addr_r       <= line_addr_r + fbo_pkg::ADDR_W'(width_r);
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   vsync_on_restart_a: assert property (tick && restart_pend_r && outen |=> frame_sync_out)
      else $error("no vertical sync after frame restart");
   hsync_on_req_a: assert property (take_line |=> line_sync_out)
      else $error("horizontal sync missing after line request");
   hsync_ends_a: assert property (tick && !take_line |=> !line_sync_out)
      else $error("horizontal sync held past one output clock");
   req_pending_a: assert property (line_evt |=> line_pend_r)
      else $error("line request lost");
   field_low_a: assert property (!cfg_r[fbo_pkg::BIT_INTERLC] && tick |=> !odd_field_flag)
      else $error("field flag high without interlace");
   restart_clears_a: assert property (tick && restart_pend_r |=> st_r == fbo_pkg::FBO_IDLE && line_cnt_r == 11'h000)
      else $error("frame restart did not reset position");
   pixel_timed_a: assert property (!tick |=> $stable(pixel_bus_out) && $stable(line_sync_out))
      else $error("output changed off the output clock");
   stall_raise_a: assert property (do_pix && !buf_valid |=> supply_stall && $stable(pixel_bus_out))
      else $error("stall not raised while data missing");
   resync_mode_a: assert property (!ctrl_r[fbo_pkg::BIT_FLOCK] |=> resync_pulse_out_n)
      else $error("resync pulse outside frame-sync mode");
   delay_end_a: assert property (tick && st_r == fbo_pkg::FBO_DELAY && dly_r == 11'h001 && buf_valid
                                 && !restart_pend_r |=> st_r != fbo_pkg::FBO_DELAY)
      else $error("start delay did not end");
   line_limit_a: assert property (line_cnt_r <= vlen_r || $past(vlen_r) != vlen_r || $past(wr_go))
      else $error("line count beyond programmed length");
   pix_limit_a: assert property (st_r == fbo_pkg::FBO_ACTIVE |-> pix_cnt_r < hwidth_r || $past(wr_go))
      else $error("pixel count beyond programmed width");
endmodule : fbo_port

/* verification/fbo_scaler_model.sv */
`timescale 1ns/1ps
module fbo_scaler_model (
   // Link towards the port
   output logic                           port_reference_clock,
   output logic                           line_request_in_n,
   output logic                           frame_restart_in_n,
   // Link from the port
   input  wire logic                      forwarded_pixel_clock,
   input  wire logic [fbo_pkg::PIX_W-1:0] pixel_bus_out,
   input  wire logic                      line_sync_out,
   input  wire logic                      frame_sync_out,
   input  wire logic                      resync_pulse_out_n
);
   int hs_cnt = 0, vs_cnt = 0, rs_cnt = 0, pix_cnt = 0, clk_cnt = 0;
   // Reference runs free, phase unrelated to mclk
   initial begin
      port_reference_clock = 1'b0;
      line_request_in_n = 1'b1;
      frame_restart_in_n = 1'b1;
      #137;
      forever #400 port_reference_clock = ~port_reference_clock;
   end
   always @(posedge line_sync_out) hs_cnt++;
   always @(posedge frame_sync_out) vs_cnt++;
   always @(negedge resync_pulse_out_n) rs_cnt++;
   always @(posedge forwarded_pixel_clock) clk_cnt++;
   // Every new pixel differs from the last, so changes count pixels
   always @(pixel_bus_out) pix_cnt++;
   task automatic pulse(input bit frame);
      @(posedge port_reference_clock);
      if (frame) frame_restart_in_n = 1'b0;
      else line_request_in_n = 1'b0;
      repeat (2) @(posedge port_reference_clock);
      frame_restart_in_n = 1'b1;
      line_request_in_n = 1'b1;
      repeat (4) @(posedge port_reference_clock);
   endtask : pulse
endmodule : fbo_scaler_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
   typedef struct {logic [7:0] a; logic [31:0] rv, wd, ex;} fbo_row_s;
   logic                        mclk, rst, avs_read, avs_write, avs_waitrequest;
   logic [7:0]                  avs_address;
   logic [31:0]                 avs_writedata, avs_readdata, q;
   logic [3:0]                  avs_byteenable;
   logic                        port_reference_clock, line_request_in_n, frame_restart_in_n, data_request_in;
   logic                        forwarded_pixel_clock, line_sync_out, frame_sync_out, odd_field_flag;
   logic                        supply_stall, resync_pulse_out_n, store_pixel_valid, store_pixel_ready;
   logic                        store_fetch_start, store_double_buffer, store_passthrough, store_output_exceeds;
   logic [fbo_pkg::PIX_W-1:0]   pixel_bus_out, store_pixel_data;
   logic [fbo_pkg::ADDR_W-1:0]  store_fetch_addr;
   logic [fbo_pkg::CNT_W-1:0]   store_fetch_len;
   logic [7:0]                  fill_cnt;
   int                          errors = 0, samples_checked = 0, fetches = 0, fl = 0, p;
   fbo_row_s rows [10] = '{
      '{8'h08, 0, 32'hffff, 32'h3ff}, '{8'h3c, 0, 32'hffff, 32'h7ff},
      '{8'h40, 0, 32'hffff, 32'hfff}, '{8'h44, 0, 32'hffff, 32'h07f},
      '{8'h48, 0, 32'hffff, 32'h7ff}, '{8'h4c, 0, 32'hffff, 32'h7ff},
      '{8'h50, 0, 32'hffff, 32'h7ff}, '{8'h58, 0, 32'hffff, 32'h003},
      '{8'h54, 4, 32'hffff, 32'h004}, '{8'h7c, 0, 32'hffff, 32'h000}};

   fbo_port dut (.*);
   fbo_scaler_model sc (.*);

   // ----------------------------------------------------------------
   // Frame store stand-in: middle byte differs from the outer ones
   // ----------------------------------------------------------------
   assign store_pixel_data = {fill_cnt, ~fill_cnt, fill_cnt};
   always @(posedge mclk or posedge rst) begin
      if (rst) fill_cnt <= 8'h00;
      else if (store_pixel_ready && store_pixel_valid) fill_cnt <= fill_cnt + 8'h01;
   end
   // Line index within the frame restarts with every frame restart
   always @(negedge frame_restart_in_n) fl = 0;
   always @(posedge mclk) begin
      if (store_fetch_start === 1'b1) begin
         check(32'(store_fetch_addr), 32'h5aabc + 32'h3 * fl);
         check(32'(store_fetch_len), 32'h3);
         fetches++;
         fl++;
      end
   end

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      if (n == 50) errors++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic ticks(input int n);
      repeat (n) @(posedge port_reference_clock);
      @(posedge mclk);
   endtask : ticks

   task automatic line(input int exp);
      p = sc.pix_cnt;
      sc.pulse(0);
      ticks(12);
      check(sc.pix_cnt - p, exp);
   endtask : line

   task automatic print_verdict;
      if (errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (40000) @(posedge mclk);
      errors++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'h3;
      data_request_in = 1'b0;
      store_pixel_valid = 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      foreach (rows[i]) begin
         bus(0, rows[i].a, 0);
         check(q, rows[i].rv);
         bus(1, rows[i].a, rows[i].wd);
         bus(0, rows[i].a, 0);
         check(q, rows[i].ex);
      end
      bus(1, 8'h3c, 32'h3);
      bus(1, 8'h40, 32'habc);
      bus(1, 8'h44, 32'h5a);
      bus(1, 8'h48, 32'h2);
      bus(1, 8'h4c, 32'h3);
      avs_byteenable <= 4'h1;
      bus(1, 8'h50, 32'h0705);
      avs_byteenable <= 4'h3;
      bus(0, 8'h50, 0);
      check(q, 32'h705);
      bus(1, 8'h50, 32'h5);
      bus(1, 8'h58, 32'h2);
      bus(1, 8'h08, 32'h350);
      check({store_output_exceeds, store_passthrough, store_double_buffer}, 32'h1);
      sc.pulse(1);
      ticks(2);
      check(sc.vs_cnt, 1);
      check(odd_field_flag, 1);
      check(sc.rs_cnt, 1);
      for (int i = 0; i < 3; i++) line(i < 2 ? 5 : 0);
      check(sc.hs_cnt, 3);
      check(fetches, 2);
      p = sc.clk_cnt;
      ticks(10);
      check(sc.clk_cnt - p, 10);
      // Frame lock off, luma/chroma source on
      bus(1, 8'h08, 32'h150);
      bus(1, 8'h58, 32'h3);
      sc.pulse(1);
      ticks(2);
      check(odd_field_flag, 0);
      check(sc.rs_cnt, 1);
      check(sc.vs_cnt, 2);
      line(5);
      check(pixel_bus_out[15:8], 0);
      check(pixel_bus_out[23:16], 8'(~pixel_bus_out[7:0]));
      // Starved store: pixel held while stalled
      store_pixel_valid <= 1'b0;
      sc.pulse(1);
      line(0);
      check(supply_stall, 1);
      p = sc.pix_cnt;
      store_pixel_valid <= 1'b1;
      ticks(12);
      check(sc.pix_cnt - p, 5);
      check(supply_stall, 0);
      // Restart in mid-line drops back to idle with no lines counted
      sc.pulse(0);
      sc.pulse(1);
      ticks(2);
      bus(0, 8'h54, 0);
      check(q & 32'h07ff001c, 32'h4);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      bus(0, 8'h08, 0);
      check(q, 0);
      print_verdict();
   end
endmodule : tb
